// ### rtl/csrs_pkg.sv
// Purpose: Constants and types for the startup/shutdown reset sequencer.
// Assumes: 100 MHz pclk, APB register access.
// Notes: What this block does is listed below.
package csrs_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int CSRS_NSTEP = 32;          // Steps per sequence
  localparam int CSRS_NFAB = 16;           // Fabric resets
  localparam int CSRS_NPLL = 4;            // PLL lock inputs
  localparam int CSRS_NSTAGE = 3;          // Sequencer stages

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] CSRS_OFF_CTRL = 8'h00;    // Control
  localparam logic [7:0] CSRS_OFF_STAT = 8'h04;    // Status
  localparam logic [7:0] CSRS_OFF_PLLW = 8'h08;    // Per-step PLL wait enable
  localparam logic [7:0] CSRS_OFF_PLLSEL = 8'h0C;  // PLL lock select mask
  localparam logic [7:0] CSRS_OFF_STAG = 8'h10;    // Stagger gap in cycles

  // ----------------------------------------------------------------
  // Control fields
  // ----------------------------------------------------------------
  localparam int CSRS_CTRL_START = 0;     // Write 1: startup request (pulse)
  localparam int CSRS_CTRL_SHUT = 1;      // Write 1: shutdown request (pulse)
  localparam int CSRS_CTRL_CRCEN = 2;     // Full CRC checking enable
  localparam int CSRS_CTRL_STG_LSB = 4;   // Stage select, 2 bits

  // ----------------------------------------------------------------
  // Reset values and timing
  // ----------------------------------------------------------------
  localparam logic [31:0] CSRS_RST_PLLW = 32'h0000_0000;
  localparam logic [3:0] CSRS_RST_PLLSEL = 4'hF;
  localparam int CSRS_STAGGER_NS = 100;   // Default gap between steps
  localparam int CSRS_CLK_MHZ = 100;
  localparam int CSRS_STAGGER_CYC = (CSRS_STAGGER_NS * CSRS_CLK_MHZ + 999) / 1000;
  localparam logic [7:0] CSRS_RST_STAG = 8'(CSRS_STAGGER_CYC);

  // Sequencer states, Gray along idle->up->user->down
  typedef enum logic [1:0] {
    CSRS_IDLE = 2'b00,
    CSRS_UP = 2'b01,
    CSRS_USER = 2'b11,
    CSRS_DOWN = 2'b10
  } csrs_state_e;

endpackage : csrs_pkg

// ### rtl/csrs_gap_timer.sv
// Purpose: Down-counter that paces successive reset steps.
// Assumes: Single pclk domain.
// Notes: done pulses high for one cycle when the load value expires.
`timescale 1ns/1ps
`default_nettype none
module csrs_gap_timer (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic load,
  input wire logic [7:0] gap,
  output logic done
);
  typedef struct packed {
    logic [7:0] cnt;   // Cycles left
    logic run;         // Counting
    logic done;        // Expiry pulse
  } csrs_tmr_s;
  csrs_tmr_s q, d;

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    d = q;
    d.done = 1'b0;
    if (load) begin
      // Zero gap still waits one cycle
      d.cnt = (gap == 8'h00) ? 8'h01 : gap;
      d.run = 1'b1;
    end else if (q.run) begin
      if (q.cnt == 8'h01) begin
        d.run = 1'b0;
        d.done = 1'b1;
      end
      d.cnt = q.cnt - 8'h01;
    end
  end

  // Registered copy
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign done = q.done;
endmodule : csrs_gap_timer
`default_nettype wire

// ### rtl/csrs_top.sv
// Purpose: Startup/shutdown reset sequencer of the configuration unit.
// Assumes: pclk always running while stepping; pins synchronised here.
// Notes: Reset bit = 1 means that reset is asserted.
//
// The address map and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module csrs_top
  import csrs_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic config_rst_n,                 // Configuration reset pin
  input wire logic programming_complete_flag,    // Bitstream load finished
  input wire logic crc_match,                    // Accumulated CRC equals expected
  input wire logic [CSRS_NPLL-1:0] pll_lock,     // PLL lock pins
  output logic [CSRS_NFAB-1:0] fabric_rst,       // Fabric resets, 1 = held
  output logic [CSRS_NFAB-1:0] hardip_rst,       // Hard IP resets, 1 = held
  output logic user_mode_indicator               // Device in user mode
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] rst_s;          // Config reset sync
    logic [1:0] done_s;         // Programming complete sync
    logic [1:0] crc_s;          // CRC match sync
    logic [CSRS_NPLL-1:0] pll_s1;
    logic [CSRS_NPLL-1:0] pll_s2;
    csrs_state_e st;            // Sequencer state
    logic [5:0] step;           // Steps released, 0..32
    logic wait_gap;             // Waiting on stagger timer
    logic kick;                 // Load stagger timer
    logic [31:0] rst;           // Reset vector, fabric low half
    logic user;                 // User-mode indicator
    logic crcen;                // Full CRC checking
    logic [1:0] stage;          // Active stage
    logic [31:0] pllw;          // Per-step PLL wait
    logic [3:0] pllsel;         // Which PLLs must lock
    logic [7:0] stag;           // Stagger gap
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } csrs_s;
  csrs_s q, d;

  logic gap_done;        // Stagger timer expiry
  logic acc;             // APB access phase
  logic wr_ctrl;         // Control write this cycle
  logic plls_ok;         // Selected PLLs locked
  logic [4:0] idx;       // Step being worked on

  // Pacing between steps keeps fabric current steps small
  csrs_gap_timer u_gap (
    .pclk(pclk),
    .presetn(presetn),
    .load(q.kick),
    .gap(q.stag),
    .done(gap_done)
  );

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    d.kick = 1'b0;
    d.pready = 1'b0;
    d.pslverr = 1'b0;
    // Pins pass two flops before use
    d.rst_s = {q.rst_s[0], config_rst_n};
    d.done_s = {q.done_s[0], programming_complete_flag};
    d.crc_s = {q.crc_s[0], crc_match};
    d.pll_s1 = pll_lock;
    d.pll_s2 = q.pll_s1;
    acc = psel && penable && !q.pready;
    wr_ctrl = acc && pwrite && (paddr == CSRS_OFF_CTRL);
    plls_ok = &(q.pll_s2 | ~q.pllsel);
    idx = (q.st == CSRS_DOWN) ? 5'(q.step - 6'd1) : q.step[4:0];

    // APB: one wait state, answer in the second cycle after setup
    if (acc) begin
      d.pready = 1'b1;
      if (paddr == CSRS_OFF_CTRL) begin
        if (pwrite) begin
          d.crcen = pwdata[CSRS_CTRL_CRCEN];
          // Stage 3 encoding does not exist; keep old stage
          if (pwdata[CSRS_CTRL_STG_LSB +: 2] != 2'd3) begin
            d.stage = pwdata[CSRS_CTRL_STG_LSB +: 2];
          end
        end
        d.prdata = {26'h0, q.stage, 1'b0, q.crcen, 2'b00};
      end else if (paddr == CSRS_OFF_STAT) begin
        d.prdata = {17'h0, q.user, q.st, q.step, q.pll_s2, q.done_s[1], q.crc_s[1]};
        if (pwrite) d.pslverr = 1'b1;
      end else if (paddr == CSRS_OFF_PLLW) begin
        if (pwrite) d.pllw = pwdata;
        d.prdata = q.pllw;
      end else if (paddr == CSRS_OFF_PLLSEL) begin
        if (pwrite) d.pllsel = pwdata[3:0];
        d.prdata = {28'h0, q.pllsel};
      end else if (paddr == CSRS_OFF_STAG) begin
        if (pwrite) d.stag = pwdata[7:0];
        d.prdata = {24'h0, q.stag};
      end else begin
        // Unmapped address
        d.prdata = 32'h0000_0000;
        d.pslverr = 1'b1;
      end
    end

    // Sequencer
    case (q.st)
      CSRS_IDLE: begin
        // Remain idle during power-on and programming
        // Bus clocks may run long before any request; only a start write moves us
        d.user = 1'b0;
        if (wr_ctrl && pwdata[CSRS_CTRL_START] && q.done_s[1]
            && (!q.crcen || q.crc_s[1])) begin
          d.st = CSRS_UP;
          d.kick = 1'b1;
          d.wait_gap = 1'b1;
        end
      end
      CSRS_UP: begin
        if (q.wait_gap) begin
          if (gap_done) d.wait_gap = 1'b0;
        end else if (!q.pllw[idx] || plls_ok) begin
          if (q.step == 6'd32) begin
            // Final step holds until programming complete
            if (q.done_s[1]) begin
              d.st = CSRS_USER;
              d.user = 1'b1;
            end
          end else begin
            // One reset released per step, fixed order
            d.rst[idx] = 1'b0;
            d.step = q.step + 6'd1;
            d.kick = 1'b1;
            d.wait_gap = 1'b1;
          end
        end
      end
      CSRS_USER: begin
        // Stay until a shutdown request
        if (wr_ctrl && pwdata[CSRS_CTRL_SHUT] && (!q.crcen || q.crc_s[1])) begin
          d.st = CSRS_DOWN;
          d.user = 1'b0;
          d.kick = 1'b1;
          d.wait_gap = 1'b1;
        end
      end
      CSRS_DOWN: begin
        if (q.wait_gap) begin
          if (gap_done) d.wait_gap = 1'b0;
        end else if (!q.pllw[idx] || plls_ok) begin
          if (q.step == 6'd0) begin
            d.st = CSRS_IDLE;
          end else begin
            // Reverse order re-assertion
            d.rst[idx] = 1'b1;
            d.step = q.step - 6'd1;
            d.kick = 1'b1;
            d.wait_gap = 1'b1;
          end
        end
      end
      default: d.st = CSRS_IDLE;
    endcase

    // Configuration reset overrides the sequencer state, step count, resets and user flag
    if (!q.rst_s[1]) begin
      d.st = CSRS_IDLE;
      d.step = 6'd0;
      d.rst = 32'hFFFF_FFFF;
      d.user = 1'b0;
      d.wait_gap = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
      q.st <= CSRS_IDLE;
      q.rst <= 32'hFFFF_FFFF;
      q.pllw <= CSRS_RST_PLLW;
      q.pllsel <= CSRS_RST_PLLSEL;
      q.stag <= CSRS_RST_STAG;
    end else begin
      q <= d;
    end
  end

  // Outputs straight from flops
  assign fabric_rst = q.rst[15:0];
  assign hardip_rst = q.rst[31:16];
  assign user_mode_indicator = q.user;
  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
endmodule : csrs_top
`default_nettype wire

// ### sim/csrs_far_model.sv
// Purpose: PLL side of the fabric reset domains.
// Assumes: Lock follows release of the first fabric reset.
// Notes: slow stretches lock time so the sequencer must wait.
`timescale 1ns/1ps
`default_nettype none
module csrs_far_model
  import csrs_pkg::*;
(
  input wire logic pclk,
  input wire logic slow,
  input wire logic host_valid,
  input wire logic [7:0] host_word,
  input wire logic [CSRS_NFAB-1:0] fabric_rst,
  output logic [CSRS_NPLL-1:0] pll_lock,
  output logic [127:0] host_image
);
  int cnt = 0; // Cycles since first fabric domain left reset
  // Host stand-in on an 8-bit CPU port: one word a clock, first word ends leftmost
  always @(posedge pclk) begin
    if (host_valid) host_image <= {host_image[119:0], host_word};
  end
  // Lock is lost while the domain sits in reset, as real PLLs would be
  always @(posedge pclk) begin
    cnt <= fabric_rst[0] ? 0 : cnt + 1;
    for (int i = 0; i < CSRS_NPLL; i++)
      pll_lock[i] <= cnt > (slow ? 60 : 2) * (i + 1);
  end
endmodule : csrs_far_model
`default_nettype wire

// ### sim/csrs_checker.sv
// Purpose: Port checks for the reset sequencer.
// Assumes: One pclk domain, presetn async low.
// Notes: Bound to csrs_top at the foot.
`timescale 1ns/1ps
`default_nettype none
module csrs_checker
  import csrs_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic config_rst_n,
  input wire logic programming_complete_flag,
  input wire logic [CSRS_NFAB-1:0] fabric_rst,
  input wire logic [CSRS_NFAB-1:0] hardip_rst,
  input wire logic user_mode_indicator
);
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [31:0] rv; // All resets, fabric in low half
  logic sw; // Shutdown write accepted this edge
  assign rv = {hardip_rst, fabric_rst};
  assign sw = psel && penable && !pready && pwrite && paddr == CSRS_OFF_CTRL
    && pwdata[CSRS_CTRL_SHUT];
  a_thermo_order: assert property ((rv[30:0] & ~rv[31:1]) == 31'h0)
    else $error("reset order broken");
  a_one_step: assert property (config_rst_n [*5] ##0 $changed(rv)
    |-> $countones(rv ^ $past(rv)) == 1)
    else $error("more than one reset moved");
  a_user_clear: assert property (user_mode_indicator |-> rv == 32'h0)
    else $error("user mode with reset held");
  a_done_first: assert property ($rose(user_mode_indicator)
    |-> $past(programming_complete_flag, 3))
    else $error("user mode before programming done");
  a_user_stays: assert property (config_rst_n [*3] ##0 (user_mode_indicator && !sw
    && !$past(sw)) |=> user_mode_indicator)
    else $error("user mode left without request");
  a_cfg_reset: assert property (!config_rst_n [*5]
    |-> rv == '1 && !user_mode_indicator)
    else $error("config reset not forcing idle");
  a_apb_wait: assert property ($rose(penable) |=> pready ##1 !pready)
    else $error("apb answer timing");
  a_apb_err: assert property (pready && (paddr > CSRS_OFF_STAG
    || (pwrite && paddr == CSRS_OFF_STAT)) |-> pslverr)
    else $error("apb error missing");
  c_up: cover property ($rose(user_mode_indicator));
  c_down: cover property ($fell(user_mode_indicator));
  c_cfg: cover property (!config_rst_n [*5]);
endmodule : csrs_checker
bind csrs_top csrs_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .pslverr(pslverr), .config_rst_n(config_rst_n),
  .programming_complete_flag(programming_complete_flag), .fabric_rst(fabric_rst),
  .hardip_rst(hardip_rst), .user_mode_indicator(user_mode_indicator));
`default_nettype wire

// ### sim/tb.sv
// Purpose: Self-checking bench for the reset sequencer.
// Assumes: Seed fixed; gap shortened to a few cycles.
// Notes: Reset bit 1 means held.
`timescale 1ns/1ps
`default_nettype none
module tb
  import csrs_pkg::*;
();
  logic pclk, presetn, psel, penable, pwrite, config_rst_n, slow, e, prog_ok, crc_ok, hv;
  logic [127:0] img;
  logic pready, pslverr, user;
  logic [7:0] paddr, stag, hw, hw0;
  logic [31:0] pwdata, prdata, r, d, rv;
  logic [3:0] pll_lock;
  logic [15:0] fabric_rst, hardip_rst;
  logic [1:0] stg;
  int n_errors, total_checks, nch, mg, n;
  assign rv = {hardip_rst, fabric_rst};
  csrs_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .config_rst_n(config_rst_n), .programming_complete_flag(prog_ok),
    .crc_match(crc_ok), .pll_lock(pll_lock), .fabric_rst(fabric_rst),
    .hardip_rst(hardip_rst), .user_mode_indicator(user));
  csrs_far_model far (.pclk(pclk), .slow(slow), .host_valid(hv), .host_word(hw),
    .fabric_rst(fabric_rst), .pll_lock(pll_lock), .host_image(img));
  // Clock runs free throughout
  initial begin
    pclk = 0;
    forever #5 pclk = ~pclk;
  end
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // One APB transfer; waits for pready, no fixed latency assumed
  // Sampling right after the edge reads the values that stood before it
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= wd; penable <= 0;
    @(posedge pclk);
    penable <= 1;
    do begin @(posedge pclk); end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb
  // Status word layout: user, state, step count, PLL locks, done, CRC
  function automatic logic [31:0] stat_exp(input logic u, input logic [1:0] s,
    input logic [5:0] stp, input logic [3:0] pl, input logic dn, input logic cr);
    return {17'h0, u, s, stp, pl, dn, cr};
  endfunction : stat_exp
  // Follows a sequence, counting steps and the shortest gap between them
  task automatic walk(input logic [31:0] fin);
    logic [31:0] p;
    int g;
    p = rv; nch = 0; mg = 999; g = 0; n = 0;
    while (rv !== fin && n < 3000) begin
      @(negedge pclk); n++; g++;
      if (rv !== p) begin if (nch > 0 && g < mg) mg = g; nch++; g = 0; end
      p = rv;
    end
  endtask : walk
  task automatic report_and_stop;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (20000) @(posedge pclk);
    n_errors++;
    report_and_stop();
  end
  initial begin
    presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    config_rst_n = 1; prog_ok = 0; crc_ok = 0; slow = 0; n_errors = 0; total_checks = 0;
    hv = 0; hw = 0;
    void'($urandom(53));
    repeat (10) @(posedge pclk);
    presetn <= 1;
    apb(0, CSRS_OFF_PLLW, 0); chk("pllw", r, CSRS_RST_PLLW);
    chk("okay resp", 32'(e), 32'h0);
    apb(0, CSRS_OFF_PLLSEL, 0); chk("pllsel", r, 32'(CSRS_RST_PLLSEL));
    apb(0, CSRS_OFF_STAG, 0); chk("stag", r, 32'(CSRS_RST_STAG));
    apb(0, 8'h40, 0); chk("unmapped", 32'(e), 32'h1);
    apb(1, CSRS_OFF_STAT, 32'hFFFF); chk("stat ro", 32'(e), 32'h1);
    d = $urandom;
    apb(1, CSRS_OFF_PLLW, d); apb(0, CSRS_OFF_PLLW, 0); chk("pllw rw", r, d);
    apb(1, CSRS_OFF_PLLW, 0);
    stag = 8'($urandom_range(4, 2)); stg = 2'($urandom_range(2, 0));
    apb(1, CSRS_OFF_STAG, 32'(stag));
    apb(1, CSRS_OFF_CTRL, 32'(stg) << 4); apb(1, CSRS_OFF_CTRL, 32'h30);
    apb(0, CSRS_OFF_CTRL, 0); chk("stage", 32'(r[5:4]), 32'(stg));
    apb(1, CSRS_OFF_CTRL, 32'h1); hw0 = 8'($urandom);
    // Host feeds 16 bytes one per clock while programming is still under way
    for (int i = 0; i < 16; i++) begin
      @(posedge pclk); hv <= 1; hw <= (i == 0) ? hw0 : 8'($urandom);
    end
    @(posedge pclk); hv <= 0; repeat (14) @(posedge pclk);
    chk("host order", 32'(img[127:120]), 32'(hw0));
    chk("idle hold", rv, '1);
    prog_ok <= 1; repeat (4) @(posedge pclk);
    apb(1, CSRS_OFF_CTRL, 32'h1); repeat (3) @(posedge pclk); prog_ok <= 0;
    walk(0); chk("up steps", nch, 32); chk("stagger", 32'(mg >= stag), 1);
    repeat (10) @(negedge pclk); chk("wait done", 32'(user), 0);
    @(posedge pclk); prog_ok <= 1; n = 0;
    while (user !== 1'b1 && n < 40) begin @(negedge pclk); n++; end
    chk("user", 32'(user), 1);
    apb(0, CSRS_OFF_STAT, 0);
    chk("status", r, stat_exp(1'b1, CSRS_USER, 6'(CSRS_NSTEP), 4'hF, 1'b1, 1'b0));
    apb(1, CSRS_OFF_CTRL, 32'h4); apb(1, CSRS_OFF_CTRL, 32'h6);
    repeat (20) @(negedge pclk); chk("crc gate", 32'(user), 1);
    @(posedge pclk); crc_ok <= 1; repeat (4) @(posedge pclk);
    apb(1, CSRS_OFF_CTRL, 32'h6);
    walk('1); chk("down steps", nch, 32); chk("down user", 32'(user), 0);
    apb(1, CSRS_OFF_PLLW, 32'h20); apb(1, CSRS_OFF_PLLSEL, 32'h1);
    slow <= 1; apb(1, CSRS_OFF_CTRL, 32'h5); n = 0;
    while (fabric_rst[4] !== 1'b0 && n < 500) begin @(negedge pclk); n++; end
    repeat (20) @(negedge pclk); chk("pll wait", 32'(fabric_rst), 32'hFFE0);
    @(posedge pclk); config_rst_n <= 0; repeat (6) @(negedge pclk);
    chk("cfg rst", rv, '1); chk("cfg user", 32'(user), 0);
    report_and_stop();
  end
endmodule : tb
`default_nettype wire
